// file: core/fspg_guard.sv
// Operation
// - stores executed from application code never start programming.
// - stores from loader code may program any flash address, loader included.
// - loader/application boundary follows loader_size_fuses; each side has own locks.
// - programming concurrent-read section keeps CPU running; only halting section readable.
// - programming halting section stalls CPU for whole operation; nothing readable.
// - stall choice follows the programmed target address, not the fetch address.
// - loader section always lies inside the halting section.
// - concurrent_section_busy reads one while concurrent-read section is blocked.
// - lock bits programmable by software or external modes; only chip erase restores.
// - general write and read/write lock levels never restrict store or load.
// - app locks 11: no restriction on application section.
// - app locks 10: stores to application blocked, loads free.
// - app locks 00: stores blocked, loader loads from application blocked, irq masked in application code if vectors in loader.
// - app locks 01: loader loads from application blocked, writes allowed, irq masked in application code if vectors in loader.
// - loader locks 11: no restriction on loader section.
// - loader locks 10: stores to loader blocked, loads free.
// - loader locks 00: stores blocked, application loads from loader blocked, irq masked in loader code if vectors in application.
// - loader locks 01: application loads from loader blocked, writes allowed, irq masked in loader code if vectors in application.
// - busy clears on re-enable with store enable after programming, or page load.
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`include "fspg_regs.svh"

module fspg_guard (
	input wire logic clk_i,
	input wire logic rst_i,
	// classic wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// cpu instruction side
	input wire fspg_pkg::fspg_req_t req_i,
	input wire logic [11:0] fetch_pc_i,
	output fspg_pkg::fspg_resp_t resp_o,
	output logic cpu_stall_o,
	output logic irq_mask_o,
	// flash macro side
	input wire logic flash_done_i,
	input wire logic chip_erase_i
);

	// ==========================================
	// section decode
	function automatic logic in_loader(input logic [11:0] a, input logic [1:0] sz);
		logic [11:0] base;
		base = `FSPG_LDR_BASE_0;
		case (sz)
			2'b00: base = `FSPG_LDR_BASE_0;
			2'b01: base = `FSPG_LDR_BASE_1;
			2'b10: base = `FSPG_LDR_BASE_2;
			default: base = `FSPG_LDR_BASE_3;
		endcase
		return a >= base;
	endfunction

	function automatic logic in_halting(input logic [11:0] a);
		return a >= `FSPG_HALT_BASE;
	endfunction

	fspg_pkg::fspg_state_t state_ff;
	fspg_pkg::fspg_state_t nxt_state;
	logic [4:0] ctrl_ff;
	logic busy_ff;
	logic [3:0] lock_ff;
	logic [2:0] cfg_ff;
	logic [2:0] arm_cnt_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;
	fspg_pkg::fspg_resp_t resp_ff;

	// ==========================================
	// bus decode
	wire bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	wire wr_ctrl = bus_wr & (wb_adr_i == `FSPG_ADDR_CTRL);
	wire wr_cfg = bus_wr & (wb_adr_i == `FSPG_ADDR_CFG);
	wire [1:0] size_sel = cfg_ff[`FSPG_CFG_SIZE_MSB:`FSPG_CFG_SIZE_LSB];
	wire vec_in_loader = cfg_ff[`FSPG_CFG_VEC_LDR];
	// controls accepted only when idle; a write mid-operation is dropped
	wire ctrl_accept = wr_ctrl & wb_dat_i[`FSPG_CTRL_STORE_EN] & (state_ff == fspg_pkg::FSPG_IDLE);

	// ==========================================
	// access decision
	wire pc_ldr = in_loader(req_i.pc, size_sel);
	wire tgt_ldr = in_loader(req_i.target, size_sel);
	wire app_lo = lock_ff[`FSPG_LOCK_APP_LOW];
	wire app_hi = lock_ff[`FSPG_LOCK_APP_HIGH];
	wire ldr_lo = lock_ff[`FSPG_LOCK_LDR_LOW];
	wire ldr_hi = lock_ff[`FSPG_LOCK_LDR_HIGH];
	// store permission: high bit governs loads and irq masking, low bit only writes; general lock levels unused
	wire store_ok = pc_ldr & (tgt_ldr ? ldr_lo : app_lo);
	// cross-section loads blocked by the high lock bit
	wire load_ok = tgt_ldr ? (pc_ldr | ldr_hi) : (~pc_ldr | app_hi);
	wire lock_cmd = ctrl_ff[`FSPG_CTRL_LOCKSET];
	wire armed = (state_ff == fspg_pkg::FSPG_ARMED);
	wire st_req = req_i.valid & req_i.is_store & armed;
	wire ld_req = req_i.valid & ~req_i.is_store & (state_ff != fspg_pkg::FSPG_STALL);
	// concurrent section unreadable while busy
	wire ld_blocked = busy_ff & ~in_halting(req_i.target);
	wire st_ok = st_req & (lock_cmd ? pc_ldr : store_ok);
	wire ld_ok = ld_req & load_ok & ~ld_blocked;
	wire is_prog = ctrl_ff[`FSPG_CTRL_ERASE] | ctrl_ff[`FSPG_CTRL_WRITE];
	wire prog_start = st_ok & is_prog;
	wire tgt_halt = in_halting(req_i.target);
	wire is_reen = ctrl_ff[`FSPG_CTRL_REENABLE];
	wire page_load = st_ok & ~is_prog & ~lock_cmd & ~is_reen;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			fspg_pkg::FSPG_IDLE: begin
				if (ctrl_accept) begin
					nxt_state = fspg_pkg::FSPG_ARMED;
				end
			end
			fspg_pkg::FSPG_ARMED: begin
				if (prog_start) begin
					nxt_state = tgt_halt ? fspg_pkg::FSPG_STALL : fspg_pkg::FSPG_PROG;
				end else if (st_req | (arm_cnt_ff == `FSPG_ARM_CYCLES)) begin
					nxt_state = fspg_pkg::FSPG_IDLE;
				end
			end
			fspg_pkg::FSPG_PROG, fspg_pkg::FSPG_STALL: begin
				if (flash_done_i) begin
					nxt_state = fspg_pkg::FSPG_IDLE;
				end
			end
			default: nxt_state = fspg_pkg::FSPG_IDLE;
		endcase
	end

	wire busy_set = prog_start & ~tgt_halt;
	wire busy_clr = (st_ok & is_reen) | page_load;
	wire [3:0] lock_new = lock_ff & wb_dat_i[3:0]; // bits only go programmed

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= fspg_pkg::FSPG_IDLE;
			ctrl_ff <= 5'h0_0;
			arm_cnt_ff <= 3'h0;
			busy_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (ctrl_accept) begin
				ctrl_ff <= wb_dat_i[4:0];
			end else if (nxt_state == fspg_pkg::FSPG_IDLE) begin
				ctrl_ff <= 5'h0_0;
			end
			arm_cnt_ff <= armed ? arm_cnt_ff + 3'h1 : 3'h0;
			// set wins over clear
			busy_ff <= busy_set | (busy_ff & ~busy_clr);
		end
	end

	// lock bits survive core reset; only chip erase restores them
	always_ff @(posedge clk_i) begin
		if (chip_erase_i) begin
			lock_ff <= `FSPG_LOCK_RESET;
		end else if (st_ok & lock_cmd) begin
			lock_ff <= lock_new;
		end else if (bus_wr & (wb_adr_i == `FSPG_ADDR_LOCK)) begin
			lock_ff <= lock_new;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_ff <= `FSPG_CFG_RESET;
			ack_ff <= 1'b0;
			rdata_ff <= `FSPG_ZERO_WORD;
			resp_ff <= '0;
		end else begin
			if (wr_cfg) begin
				cfg_ff <= wb_dat_i[2:0];
			end
			ack_ff <= bus_req;
			case (wb_adr_i)
				`FSPG_ADDR_CTRL: rdata_ff <= {25'h0, busy_ff, 1'b0, ctrl_ff};
				`FSPG_ADDR_LOCK: rdata_ff <= {28'h0, lock_ff};
				`FSPG_ADDR_CFG: rdata_ff <= {29'h0, cfg_ff};
				`FSPG_ADDR_STAT: rdata_ff <= {28'h0, state_ff};
				default: rdata_ff <= `FSPG_ZERO_WORD;
			endcase
			resp_ff.allowed <= st_ok | ld_ok;
			resp_ff.start_erase <= prog_start & ctrl_ff[`FSPG_CTRL_ERASE];
			resp_ff.start_write <= prog_start & ctrl_ff[`FSPG_CTRL_WRITE];
			resp_ff.start_read <= ld_ok;
			resp_ff.page_load <= page_load;
			resp_ff.lock_set <= st_ok & lock_cmd;
		end
	end

	// ==========================================
	// outputs
	wire lock_loads = vec_in_loader ? ~app_hi : ~ldr_hi;
	wire exec_other = vec_in_loader ? ~in_loader(fetch_pc_i, size_sel) : in_loader(fetch_pc_i, size_sel);
	assign irq_mask_o = lock_loads & exec_other;
	assign cpu_stall_o = (state_ff == fspg_pkg::FSPG_STALL);
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;
	assign resp_o = resp_ff;

endmodule

// file: common/fspg_regs.svh
`ifndef FSPG_REGS_SVH
`define FSPG_REGS_SVH

// ==========================================
// register offsets (byte addresses)
`define FSPG_ADDR_CTRL 8'h00
`define FSPG_ADDR_LOCK 8'h04
`define FSPG_ADDR_CFG 8'h08
`define FSPG_ADDR_STAT 8'h0c

// ==========================================
// control register fields
`define FSPG_CTRL_STORE_EN 0
`define FSPG_CTRL_ERASE 1
`define FSPG_CTRL_WRITE 2
`define FSPG_CTRL_LOCKSET 3
`define FSPG_CTRL_REENABLE 4
`define FSPG_CTRL_BUSY 6

// ==========================================
// lock register fields: app {high,low} then loader {high,low}
`define FSPG_LOCK_APP_LOW 0
`define FSPG_LOCK_APP_HIGH 1
`define FSPG_LOCK_LDR_LOW 2
`define FSPG_LOCK_LDR_HIGH 3
`define FSPG_LOCK_RESET 4'h0f

// ==========================================
// config register fields
`define FSPG_CFG_SIZE_LSB 0
`define FSPG_CFG_SIZE_MSB 1
`define FSPG_CFG_VEC_LDR 2
`define FSPG_CFG_RESET 3'h0

// ==========================================
// geometry: 12-bit word address space
`define FSPG_AW 12
`define FSPG_HALT_BASE 12'hc00
`define FSPG_LDR_BASE_0 12'hc00
`define FSPG_LDR_BASE_1 12'he00
`define FSPG_LDR_BASE_2 12'hf00
`define FSPG_LDR_BASE_3 12'hf80

// ==========================================
// timing
`define FSPG_ARM_CYCLES 3'h4
`define FSPG_ZERO_WORD 32'h0000_0000

`endif

// file: common/fspg_pkg.sv
package fspg_pkg;

	typedef enum logic [3:0] {
		FSPG_IDLE = 4'b0001,
		FSPG_ARMED = 4'b0010,
		FSPG_PROG = 4'b0100,
		FSPG_STALL = 4'b1000
	} fspg_state_t;

	typedef struct packed {
		logic valid;
		logic is_store;
		logic [11:0] pc;
		logic [11:0] target;
	} fspg_req_t;

	typedef struct packed {
		logic allowed;
		logic start_erase;
		logic start_write;
		logic start_read;
		logic page_load;
		logic lock_set;
	} fspg_resp_t;

endpackage

// file: test/fspg_checker.sv
module fspg_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire fspg_pkg::fspg_req_t req_i,
	input wire fspg_pkg::fspg_resp_t resp_o,
	input wire logic cpu_stall_o,
	input wire logic flash_done_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================
	// programming start, as seen at the response
	wire prog_go = resp_o.start_erase | resp_o.start_write;
	sequence s_app_store;
		req_i.valid && req_i.is_store && req_i.pc < 12'hc00;
	endsequence
	sequence s_halt_start;
		prog_go && $past(req_i.target) >= 12'hc00;
	endsequence
	sequence s_rww_start;
		prog_go && $past(req_i.target) < 12'hc00;
	endsequence
	// ==========================================
	// bus and response timing
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_idle_quiet: assert property (!req_i.valid |=> resp_o == '0)
		else $error("response without request");
	// ==========================================
	// permission and stall
	a_app_store_refused: assert property (s_app_store |=> !resp_o.allowed && !prog_go && !resp_o.lock_set)
		else $error("store from application code accepted");
	a_start_needs_allow: assert property (prog_go || resp_o.start_read || resp_o.lock_set |-> resp_o.allowed)
		else $error("start without permission");
	a_halt_stalls: assert property (s_halt_start |-> cpu_stall_o)
		else $error("halting section programmed without stall");
	a_rww_runs: assert property (s_rww_start |-> !cpu_stall_o)
		else $error("stall during concurrent programming");
	a_stall_holds: assert property (cpu_stall_o && !flash_done_i |=> cpu_stall_o)
		else $error("stall ended early");
	a_stall_cause: assert property ($rose(cpu_stall_o) |-> prog_go)
		else $error("stall without programming start");
endmodule

bind fspg_guard fspg_checker i_fspg_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .req_i, .resp_o,
	.cpu_stall_o, .flash_done_i);

// file: test/fspg_cpu_model.sv
module fspg_cpu_model (
	input wire logic clk_i,
	output fspg_pkg::fspg_req_t req_o,
	output logic [11:0] fetch_pc_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		req_o = '0;
		// stays at 12'hc10, loader code only with size setting 0; never fetches the busy section
		fetch_pc_o = 12'hc10;
	end
	// ==========================================
	// caller enters at a clock edge; request stands one cycle
	task issue(input logic st, input logic [11:0] pc, tgt);
		req_o <= {1'h1, st, pc, tgt};
		@(posedge clk_i);
		req_o <= '0;
	endtask
endmodule

// file: test/tb_fspg_guard.sv
module tb_fspg_guard;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = '0, rst_i = '1, cyc = '0, stb = '0, we = '0, done = '0, cerase = '0, ack, stall, irq;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000, rdat, q;
	logic [11:0] fpc;
	fspg_pkg::fspg_req_t req;
	fspg_pkg::fspg_resp_t resp;
	int error_cnt = 0, checked = 0;
	always #2 clk_i = ~clk_i;
	fspg_cpu_model i_fspg_cpu_model (.clk_i, .req_o(req), .fetch_pc_o(fpc));
	fspg_guard i_fspg_guard (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .req_i(req), .fetch_pc_i(fpc),
		.resp_o(resp), .cpu_stall_o(stall), .irq_mask_o(irq), .flash_done_i(done), .chip_erase_i(cerase));
	// ==========================================
	// shared tasks
	task report_and_stop();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, s);
		checked++;
		if (s !== e) begin
			$display("mismatch %s exp %h got %h", nm, e, s);
			error_cnt++;
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'h1 && n < 50);
		q = rdat;
		{cyc, stb} <= 2'h0;
		if (ack !== 1'h1) begin
			error_cnt++;
			report_and_stop();
		end
	endtask
	// locks are not cleared by reset, so every restart erases them
	task restart();
		rst_i <= 1'h1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'h0;
		cerase <= 1'h1;
		@(posedge clk_i);
		cerase <= 1'h0;
	endtask
	task op(input logic s, input logic [11:0] p, t, input logic e, input logic [3:0] c);
		if (s)
			wb(1, 8'h00, {28'h0, c});
		i_fspg_cpu_model.issue(s, p, t);
		#1;
		chk("resp", {e, s & e & c[1], s & e & c[2], !s & e, s & e & (c == 4'h1), s & e & c[3]}, resp);
		chk("stall", s & e & (c[1] | c[2]) & (t >= 12'hc00), stall);
		@(posedge clk_i) done <= 1'h1;
		@(posedge clk_i) done <= 1'h0;
		repeat (5) @(posedge clk_i);
	endtask
	// ==========================================
	// tests
	initial begin
		restart();
		wb(0, 8'h04, 32'h0000_0000);
		chk("lock", 32'h0000_000f, q);
		wb(0, 8'h10, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, q);
		for (int m = 0; m < 16; m++) begin
			restart();
			wb(1, 8'h04, {28'h0, m[3:0]});
			op(0, 12'hc10, 12'h100, m[1], 4'h0);
			op(0, 12'h100, 12'hc80, m[3], 4'h0);
			chk("irq", !m[3], irq);
			op(1, 12'hc10, 12'hc80, m[2], 4'h3);
			op(1, 12'hc10, 12'h100, m[0], 4'h5);
		end
		$display("lock table test done");
		restart();
		op(1, 12'h100, 12'h100, 0, 4'h3);
		op(1, 12'hc10, 12'h100, 1, 4'h3);
		wb(0, 8'h00, 32'h0000_0000);
		chk("busy", 1'h1, q[6]);
		op(0, 12'hc10, 12'h200, 0, 4'h0);
		wb(1, 8'h00, 32'h0000_0011);
		i_fspg_cpu_model.issue(1, 12'hc10, 12'h100);
		wb(0, 8'h00, 32'h0000_0000);
		chk("busy", 1'h0, q[6]);
		op(1, 12'hc10, 12'h100, 1, 4'h3);
		op(1, 12'hc10, 12'h100, 1, 4'h1);
		wb(0, 8'h00, 32'h0000_0000);
		chk("busy", 1'h0, q[6]);
		op(1, 12'hc10, 12'h000, 1, 4'h9);
		$display("busy test done");
		restart();
		wb(1, 8'h08, 32'h0000_0003);
		op(1, 12'hc10, 12'h100, 0, 4'h3);
		op(1, 12'hf90, 12'hc10, 1, 4'h5);
		wb(1, 8'h04, 32'h0000_0000);
		wb(1, 8'h04, 32'h0000_000f);
		wb(0, 8'h04, 32'h0000_0000);
		chk("lock", 32'h0000_0000, q);
		wb(1, 8'h08, 32'h0000_0007);
		chk("irq", 1'h1, irq);
		$display("size test done");
		report_and_stop();
	end
endmodule
